// >>> pkg/tbw_defs.vh
`ifndef TBW_DEFS_VH
`define TBW_DEFS_VH

// ****************************************************************
// Block addresses
// ****************************************************************
`define TBW_BLK_RESET_LAST  8'h04
`define TBW_BLK_CNT_FIRST   8'h05
`define TBW_BLK_CNT_RELOAD  8'h06
`define TBW_BLK_USER_FIRST  8'h07
`define TBW_BLK_USER_LAST   8'h0F
`define TBW_BLK_SYSTEM      8'hFF
`define TBW_IDX_SYSTEM      5'h10
`define TBW_NUM_WORDS       17

// ****************************************************************
// Field positions in the system block and the reload counter block
// ****************************************************************
`define TBW_LOCK_MSB        31
`define TBW_LOCK_LSB        16
`define TBW_ZERO_BIT        15
`define TBW_RSVD_MSB        14
`define TBW_RSVD_LSB        8
`define TBW_ID_MSB          7
`define TBW_ID_LSB          0
`define TBW_RELOAD_MSB      31
`define TBW_RELOAD_LSB      21

// ****************************************************************
// Initial and reset values
// ****************************************************************
`define TBW_CNT_FIRST_INIT  32'hFFFFFFFE
`define TBW_CNT_RELOAD_INIT 32'hFFFFFFFF
`define TBW_BLANK_INIT      32'hFFFFFFFF
`define TBW_SYSTEM_INIT     32'hFFFF7FFF
`define TBW_LOCK_RESET      16'h0000
`define TBW_LFSR_SEED       8'hA5

// ****************************************************************
// Timing
// ****************************************************************
`define TBW_PROG_TIME_US    5000
`define TBW_CLK_MHZ         10
// Programming time in clock cycles, 5 ms at 10 MHz
`define TBW_PROG_CYCLES     17'h0C350

`endif

// >>> hw/tbw_block_mem.v
`timescale 1ns/10ps
`include "tbw_defs.vh"

module tbw_block_mem (
  input  wire        clock_i,   // System clock
  input  wire        rst_b_i,   // Power-up reset, read port only
  input  wire        init_i,    // Factory initialisation pulse
  input  wire        we_i,      // Commit strobe
  input  wire [4:0]  waddr_i,   // Word index to program
  input  wire [31:0] wdata_i,   // Word to program
  input  wire [4:0]  raddr_i,   // Word index to read
  output reg  [31:0] rdata_o    // Registered read data
);

  wire [31:0] word_w [0:`TBW_NUM_WORDS-1];

  // ****************************************************************
  // Nonvolatile words, no reset
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `TBW_NUM_WORDS; g = g + 1) begin : g_word
      reg [31:0] word_r;
      always @(posedge clock_i) begin
        if (init_i) begin
          if (g == 5)
            word_r <= `TBW_CNT_FIRST_INIT;   // see (RULE_02)
          else if (g == 6)
            word_r <= `TBW_CNT_RELOAD_INIT;  // see (RULE_02)
          else if (g == 16)
            word_r <= `TBW_SYSTEM_INIT;
          else
            word_r <= `TBW_BLANK_INIT;
        end else if (we_i && (waddr_i == g)) begin
          word_r <= wdata_i;
        end
      end
      assign word_w[g] = word_r;
    end
  endgenerate

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i)
      rdata_o <= 32'h00000000;
    else if (raddr_i < `TBW_NUM_WORDS)
      rdata_o <= word_w[raddr_i];
    else
      rdata_o <= 32'h00000000;
  end

endmodule

// >>> hw/tbw_write_policy.v
`timescale 1ns/10ps
`include "tbw_defs.vh"

// Overview of operation
// (RULE_01) Counter write accepted only if strictly lower
// (RULE_02) Counters start FFFFFFFE and FFFFFFFF
// (RULE_03) Zero counter is empty, never raised
// (RULE_04) Reader writes full new count value
// (RULE_05) Power loss mid-program keeps old value
// (RULE_06) Locked counter refuses all writes
// (RULE_07) Reload bits change arms erase cycle
// (RULE_08) Erase armed until power-off or Select
// (RULE_09) User blocks 7-15 erased then programmed
// (RULE_10) System block clear-only, all-zero frozen
// (RULE_11) System bit 16+n locks block n
// (RULE_12) Cleared lock bit never restored
// (RULE_13) Lock pattern loaded on Select only
// (RULE_14) Mask option gives fixed identifier, no random
// (RULE_15) Unarmed resettable write ANDs, zero frozen
// (RULE_16) Armed resettable write replaces contents
// (RULE_17) System bit 15 zero, 14-8 kept
module tbw_write_policy #(
  parameter [16:0] PROG_CYCLES = `TBW_PROG_CYCLES
) (
  input  wire        clock_i,        // 10 MHz clock
  input  wire        rst_b_i,        // Power-up reset, active low
  input  wire        factory_init_i, // Load initial contents pulse
  input  wire        mask_opt_i,     // Fixed identifier mask strap
  input  wire        rd_req_i,       // Block read command pulse
  input  wire        wr_req_i,       // Block write command pulse
  input  wire [7:0]  addr_i,         // Block address
  input  wire [31:0] wdata_i,        // New block value
  input  wire        select_i,       // Select with matching identifier pulse
  input  wire        new_id_i,       // Draw new random identifier pulse
  output reg  [31:0] rdata_o,        // Read data
  output reg         rd_valid_o,     // Read data valid pulse
  output reg         wr_done_o,      // Write committed pulse
  output reg         wr_refused_o,   // Write refused pulse
  output reg         busy_o,         // Command in progress
  output reg         erase_armed_o,  // Erase cycle armed
  output reg  [15:0] lock_o,         // Loaded write locks, 1 = writable
  output reg  [7:0]  sel_id_o,       // Selection identifier
  output reg         random_id_en_o  // Random identifier in use
);

  localparam [2:0] S_BOOT  = 3'h0;
  localparam [2:0] S_IDLE  = 3'h1;
  localparam [2:0] S_FETCH = 3'h2;
  localparam [2:0] S_EVAL  = 3'h3;
  localparam [2:0] S_PROG  = 3'h4;
  localparam [2:0] S_SYSLD = 3'h5;

  reg  [2:0]  state_r;
  reg  [4:0]  idx_r;
  reg         idx_ok_r;
  reg         is_wr_r;
  reg         is_sel_r;
  reg         sel_pend_r;
  reg  [31:0] wdata_r;
  reg  [31:0] new_r;
  reg  [16:0] prog_cnt_r;
  reg         mem_we_r;
  reg         arm_r_commit;
  reg         mask_r;
  reg         strap_done_r;
  reg  [7:0]  lfsr_r;
  reg         arm_nxt;
  reg         accept_nxt;
  reg  [31:0] val_nxt;
  wire [31:0] mem_rdata_w;
  wire [31:0] old_w;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function [5:0] blk_index;
    input [7:0] a;
    begin
      if (a == `TBW_BLK_SYSTEM)
        blk_index = {1'b1, `TBW_IDX_SYSTEM};
      else if (a <= `TBW_BLK_USER_LAST)
        blk_index = {1'b1, a[4:0]};
      else
        blk_index = 6'h00;
    end
  endfunction

  tbw_block_mem u_mem (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .init_i  (factory_init_i),
    .we_i    (mem_we_r),
    .waddr_i (idx_r),
    .wdata_i (new_r),
    .raddr_i (idx_r),
    .rdata_o (mem_rdata_w)
  );

  assign old_w = mem_rdata_w;

  // ****************************************************************
  // Write policy per block
  // ****************************************************************
  always @* begin
    accept_nxt = 1'b0;
    val_nxt    = old_w;
    arm_nxt    = 1'b0;
    if (!idx_ok_r) begin
      accept_nxt = 1'b0;
    end else if (idx_r == `TBW_IDX_SYSTEM) begin
      if (old_w != 32'h00000000) begin                            // see (RULE_10)
        accept_nxt = 1'b1;
        val_nxt[`TBW_LOCK_MSB:`TBW_LOCK_LSB] = old_w[`TBW_LOCK_MSB:`TBW_LOCK_LSB] &
                                             wdata_r[`TBW_LOCK_MSB:`TBW_LOCK_LSB]; // see (RULE_12)
        val_nxt[`TBW_ZERO_BIT] = 1'b0;                             // see (RULE_17)
        if (!mask_r)
          val_nxt[`TBW_ID_MSB:`TBW_ID_LSB] = old_w[`TBW_ID_MSB:`TBW_ID_LSB] &
                                             wdata_r[`TBW_ID_MSB:`TBW_ID_LSB];
      end
    end else if (!lock_o[idx_r[3:0]]) begin
      accept_nxt = 1'b0;                                           // see (RULE_06) (RULE_11)
    end else if (idx_r <= `TBW_BLK_RESET_LAST) begin
      if (erase_armed_o) begin
        accept_nxt = 1'b1;
        val_nxt    = wdata_r;                                      // see (RULE_16)
      end else if (old_w != 32'h00000000) begin
        accept_nxt = 1'b1;
        val_nxt    = old_w & wdata_r;                              // see (RULE_15)
      end
    end else if (idx_r <= `TBW_BLK_CNT_RELOAD) begin
      if (wdata_r < old_w) begin                                   // see (RULE_01) (RULE_03)
        accept_nxt = 1'b1;
        val_nxt    = wdata_r;                                      // see (RULE_04)
        if (idx_r == `TBW_BLK_CNT_RELOAD)
          arm_nxt = wdata_r[`TBW_RELOAD_MSB:`TBW_RELOAD_LSB] !=
                    old_w[`TBW_RELOAD_MSB:`TBW_RELOAD_LSB];        // see (RULE_07)
      end
    end else begin
      accept_nxt = 1'b1;
      val_nxt    = wdata_r;                                        // see (RULE_09)
    end
  end

  // ****************************************************************
  // Mask strap capture after reset release
  // ****************************************************************
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mask_r       <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      mask_r       <= mask_opt_i;
      strap_done_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Identifier source
  // ****************************************************************
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lfsr_r         <= `TBW_LFSR_SEED;
      sel_id_o       <= `TBW_LFSR_SEED;
      random_id_en_o <= 1'b1;
    end else begin
      lfsr_r         <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      random_id_en_o <= !mask_r;                                   // see (RULE_14)
      if (state_r == S_SYSLD && mask_r)
        sel_id_o <= old_w[`TBW_ID_MSB:`TBW_ID_LSB];               // see (RULE_14)
      else if (new_id_i && !mask_r)
        sel_id_o <= lfsr_r;
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r       <= S_BOOT;
      idx_r         <= 5'h00;
      idx_ok_r      <= 1'b0;
      is_wr_r       <= 1'b0;
      is_sel_r      <= 1'b0;
      sel_pend_r    <= 1'b0;
      wdata_r       <= 32'h00000000;
      new_r         <= 32'h00000000;
      prog_cnt_r    <= 17'h00000;
      mem_we_r      <= 1'b0;
      arm_r_commit  <= 1'b0;
      rdata_o       <= 32'h00000000;
      rd_valid_o    <= 1'b0;
      wr_done_o     <= 1'b0;
      wr_refused_o  <= 1'b0;
      busy_o        <= 1'b1;
      erase_armed_o <= 1'b0;                                       // see (RULE_08)
      lock_o        <= `TBW_LOCK_RESET;
    end else begin
      mem_we_r     <= 1'b0;
      rd_valid_o   <= 1'b0;
      wr_done_o    <= 1'b0;
      wr_refused_o <= 1'b0;
      if (select_i)
        sel_pend_r <= 1'b1;
      if (mem_we_r && arm_r_commit)
        erase_armed_o <= 1'b1;                                     // see (RULE_07)
      else if (select_i)
        erase_armed_o <= 1'b0;                                     // see (RULE_08)
      case (state_r)
        S_BOOT: begin
          if (strap_done_r) begin
            idx_r    <= `TBW_IDX_SYSTEM;
            is_sel_r <= 1'b0;
            state_r  <= S_SYSLD;
          end
        end
        S_IDLE: begin
          busy_o <= 1'b0;
          if (sel_pend_r || select_i) begin
            sel_pend_r <= 1'b0;
            idx_r      <= `TBW_IDX_SYSTEM;
            is_sel_r   <= 1'b1;
            busy_o     <= 1'b1;
            prog_cnt_r <= 17'h00000;
            state_r    <= S_SYSLD;
          end else if ((rd_req_i || wr_req_i) && !factory_init_i) begin
            {idx_ok_r, idx_r} <= blk_index(addr_i);
            is_wr_r           <= wr_req_i;
            wdata_r           <= wdata_i;
            busy_o            <= 1'b1;
            state_r           <= S_FETCH;
          end
        end
        S_FETCH: begin
          state_r <= S_EVAL;
        end
        S_EVAL: begin
          if (!is_wr_r) begin
            rdata_o    <= idx_ok_r ? old_w : 32'h00000000;
            rd_valid_o <= 1'b1;
            state_r    <= S_IDLE;
          end else if (accept_nxt) begin
            new_r      <= val_nxt;
            arm_r_commit <= arm_nxt;
            prog_cnt_r <= 17'h00000;
            state_r    <= S_PROG;
          end else begin
            wr_refused_o <= 1'b1;
            state_r      <= S_IDLE;
          end
        end
        S_PROG: begin
          // Word changes only at the end, so reset mid-cycle keeps old data
          if (prog_cnt_r >= PROG_CYCLES - 17'h00001) begin
            mem_we_r  <= 1'b1;                                     // see (RULE_05)
            wr_done_o <= 1'b1;
            state_r   <= S_IDLE;
          end else begin
            prog_cnt_r <= prog_cnt_r + 17'h00001;
          end
        end
        S_SYSLD: begin
          if (prog_cnt_r[0]) begin
            prog_cnt_r <= 17'h00000;
            if (is_sel_r)
              lock_o <= old_w[`TBW_LOCK_MSB:`TBW_LOCK_LSB];       // see (RULE_13)
            state_r <= S_IDLE;
          end else begin
            prog_cnt_r <= 17'h00001;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bench/tbw_write_policy_asserts.sv
`timescale 1ns/10ps
module tbw_write_policy_asserts #(
  parameter [16:0] PROG_CYCLES = 17'd4
) (
  input wire        clock_i,       // Clock
  input wire        rst_b_i,       // Reset, active low
  input wire        rd_req_i,      // Read command
  input wire        wr_req_i,      // Write command
  input wire [7:0]  addr_i,        // Block address
  input wire        select_i,      // Select
  input wire [31:0] rdata_o,       // Read data
  input wire        rd_valid_o,    // Read valid
  input wire        wr_done_o,     // Write committed
  input wire        wr_refused_o,  // Write refused
  input wire        busy_o,        // Busy
  input wire        erase_armed_o, // Erase armed
  input wire [15:0] lock_o         // Loaded locks
);
  // ************************************
  // Command age and address tracking
  // ************************************
  reg  [7:0]  addr_q;
  reg  [17:0] age_q;
  reg  [3:0]  sel_q;
  wire        take = !busy_o && (rd_req_i || wr_req_i);
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= 8'h00;
      age_q  <= 18'h3FFFF;
      sel_q  <= 4'hF;
    end else begin
      if (take) begin
        addr_q <= addr_i;
        age_q  <= 18'h00000;
      end else if (age_q != 18'h3FFFF) begin
        age_q <= age_q + 18'h00001;
      end
      sel_q <= select_i ? 4'h0 : ((sel_q == 4'hF) ? sel_q : sel_q + 4'h1);
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_done_time;
    wr_done_o |-> age_q >= PROG_CYCLES + 18'd1 && age_q <= PROG_CYCLES + 18'd4;
  endproperty
  a_done_time: assert property (p_done_time) else $error("commit time wrong");
  property p_refuse_fast;
    wr_refused_o |-> age_q >= 18'd1 && age_q <= 18'd4;
  endproperty
  a_refuse_fast: assert property (p_refuse_fast) else $error("refusal time wrong");
  property p_one_answer;
    (wr_done_o || wr_refused_o) |-> !(wr_done_o && wr_refused_o) ##1 !(wr_done_o || wr_refused_o);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("answer not one pulse");
  property p_commit_unlocked;
    wr_done_o |-> addr_q == 8'hFF || lock_o[addr_q[3:0]];
  endproperty
  a_commit_unlocked: assert property (p_commit_unlocked) else $error("locked block written");
  property p_lock_sel;
    sel_q >= 4'h8 |-> $stable(lock_o);
  endproperty
  a_lock_sel: assert property (p_lock_sel) else $error("locks moved without select");
  property p_arm_src;
    $rose(erase_armed_o) |-> addr_q == 8'h06 && (wr_done_o || $past(wr_done_o));
  endproperty
  a_arm_src: assert property (p_arm_src) else $error("arming without reload");
  property p_arm_drop;
    select_i |-> ##[1:8] !erase_armed_o;
  endproperty
  a_arm_drop: assert property (p_arm_drop) else $error("erase kept after select");
  property p_sys_bit15;
    rd_valid_o && addr_q == 8'hFF |-> !rdata_o[15];
  endproperty
  a_sys_bit15: assert property (p_sys_bit15) else $error("system bit 15 set");
  property p_busy_hold;
    wr_req_i && !busy_o |=> busy_o [*3];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  c_arm: cover property ($rose(erase_armed_o));
  c_refuse: cover property (wr_refused_o);
  c_commit6: cover property (wr_done_o && addr_q == 8'h06);
endmodule

// >>> bench/tbw_reader.sv
`timescale 1ns/10ps
module tbw_reader (
  input  wire        clock_i,      // Tag clock
  input  wire        busy_i,       // Tag busy
  input  wire        rd_valid_i,   // Read answer
  input  wire        wr_done_i,    // Write committed
  input  wire        wr_refused_i, // Write refused
  input  wire [31:0] rdata_i,      // Read data
  output reg         rd_req_o,     // Read command
  output reg         wr_req_o,     // Write command
  output reg         select_o,     // Select command
  output reg  [7:0]  addr_o,       // Block address
  output reg  [31:0] wdata_o       // Whole new word
);
  // ************************************
  // Reader commands
  // ************************************
  reg [31:0] rdat;
  reg        ok;
  integer    n;
  initial begin
    rd_req_o = 1'b0;
    wr_req_o = 1'b0;
    select_o = 1'b0;
    addr_o   = 8'h00;
    wdata_o  = 32'h00000000;
  end
  task post(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
      n = 0;
      while (busy_i !== 1'b0 && n < 200) begin
        @(posedge clock_i);
        #1;
        n = n + 1;
      end
      wr_req_o = w;
      rd_req_o = !w;
      addr_o   = a;
      wdata_o  = d;
      @(posedge clock_i);
      #1;
      wr_req_o = 1'b0;
      rd_req_o = 1'b0;
      addr_o   = ~a;
      wdata_o  = ~d;
    end
  endtask
  task cmd(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
      post(w, a, d);
      n = 0;
      while (!(rd_valid_i || wr_done_i || wr_refused_i) && n < 40) begin
        @(posedge clock_i);
        #1;
        n = n + 1;
      end
      rdat = rdata_i;
      ok   = wr_done_i;
      if (!(rd_valid_i || wr_done_i || wr_refused_i)) begin
        rdat = 32'hXXXXXXXX;
        ok   = 1'bx;
      end
    end
  endtask
  task sel;
    begin
      select_o = 1'b1;
      @(posedge clock_i);
      #1;
      select_o = 1'b0;
      repeat (6) @(posedge clock_i);
      #1;
    end
  endtask
endmodule

// >>> bench/tag_block_write_policy_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) \
  begin \
    n_compared = n_compared + 1; \
    if ((s) !== (e)) begin \
      miscompares = miscompares + 1; \
      $display("Error %s expected %h seen %h", nm, e, s); \
    end \
  end
module tag_block_write_policy_test;
  reg         clock_i;
  reg         rst_b_i;
  reg         init;
  reg         mask;
  wire        rd_req, wr_req, sel, busy, rd_valid, wr_done, wr_ref, armed, rnd_en;
  wire [7:0]  addr, sel_id;
  wire [31:0] wdata, rdata;
  wire [15:0] lock;
  integer     miscompares;
  integer     n_compared;
  tbw_write_policy #(.PROG_CYCLES(17'd4)) i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .factory_init_i(init), .mask_opt_i(mask), .rd_req_i(rd_req), .wr_req_i(wr_req),
    .addr_i(addr), .wdata_i(wdata), .select_i(sel), .new_id_i(1'b0), .rdata_o(rdata),
    .rd_valid_o(rd_valid), .wr_done_o(wr_done), .wr_refused_o(wr_ref), .busy_o(busy),
    .erase_armed_o(armed), .lock_o(lock), .sel_id_o(sel_id), .random_id_en_o(rnd_en));
  tbw_reader i_rdr (.clock_i(clock_i), .busy_i(busy), .rd_valid_i(rd_valid),
    .wr_done_i(wr_done), .wr_refused_i(wr_ref), .rdata_i(rdata), .rd_req_o(rd_req),
    .wr_req_o(wr_req), .select_o(sel), .addr_o(addr), .wdata_o(wdata));
  // ************************************
  // Tasks and tests
  // ************************************
  task rd(input reg [7:0] a, input reg [31:0] e);
    begin
      i_rdr.cmd(1'b0, a, 32'h00000000);
      `CHK("rdata", e, i_rdr.rdat)
    end
  endtask
  task wr(input reg [7:0] a, input reg [31:0] d, input reg k);
    begin
      i_rdr.cmd(1'b1, a, d);
      `CHK("accepted", k, i_rdr.ok)
    end
  endtask
  task conclude;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    #500000;
    miscompares = miscompares + 1;
    conclude;
  end
  initial begin
    miscompares = 0;
    n_compared  = 0;
    rst_b_i     = 1'b0;
    init        = 1'b0;
    mask        = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    init = 1'b1;
    @(posedge clock_i);
    #1;
    init = 1'b0;
    i_rdr.sel;
    `CHK("lock", 16'hFFFF, lock)
    `CHK("random id", 1'b1, rnd_en)
    rd(8'h05, 32'hFFFFFFFE);
    rd(8'h06, 32'hFFFFFFFF);
    wr(8'h05, 32'hFFFFFFFD, 1'b1);
    wr(8'h05, 32'hFFFFFFFD, 1'b0);
    wr(8'h05, 32'hFFFFFFFE, 1'b0);
    rd(8'h05, 32'hFFFFFFFD);
    wr(8'h05, 32'h00000000, 1'b1);
    wr(8'h05, 32'h00000001, 1'b0);
    rd(8'h05, 32'h00000000);
    $display("test counters done");
    wr(8'h00, 32'h0F0F0F0F, 1'b1);
    wr(8'h00, 32'hFFFF0000, 1'b1);
    rd(8'h00, 32'h0F0F0000);
    wr(8'h01, 32'h00000000, 1'b1);
    wr(8'h01, 32'hFFFFFFFF, 1'b0);
    wr(8'h06, 32'hFFDFFFFF, 1'b1);
    @(posedge clock_i);
    #1;
    `CHK("armed", 1'b1, armed)
    wr(8'h00, 32'hFFFFFFFF, 1'b1);
    rd(8'h00, 32'hFFFFFFFF);
    wr(8'h01, 32'h12345678, 1'b1);
    i_rdr.sel;
    `CHK("armed", 1'b0, armed)
    wr(8'h01, 32'hFFFFFFFF, 1'b1);
    rd(8'h01, 32'h12345678);
    wr(8'h06, 32'hFFDFFFFE, 1'b1);
    @(posedge clock_i);
    #1;
    `CHK("armed", 1'b0, armed)
    $display("test reload done");
    i_rdr.post(1'b1, 8'h06, 32'hFFDFFFFD);
    repeat (4) @(posedge clock_i);
    #1;
    rst_b_i = 1'b0;
    mask    = 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    i_rdr.sel;
    rd(8'h06, 32'hFFDFFFFE);
    `CHK("random id", 1'b0, rnd_en)
    `CHK("fixed id", 8'hFF, sel_id)
    $display("test tearing done");
    wr(8'h07, 32'h12345678, 1'b1);
    wr(8'h07, 32'h87654321, 1'b1);
    rd(8'h07, 32'h87654321);
    wr(8'h0F, 32'h00000000, 1'b1);
    wr(8'h0F, 32'hA5A5A5A5, 1'b1);
    rd(8'h0F, 32'hA5A5A5A5);
    wr(8'hFF, 32'hFF3FFFFF, 1'b1);
    `CHK("lock", 16'hFFFF, lock)
    i_rdr.sel;
    `CHK("lock", 16'hFF3F, lock)
    wr(8'h07, 32'h00000000, 1'b0);
    wr(8'h06, 32'h00000000, 1'b0);
    rd(8'h06, 32'hFFDFFFFE);
    wr(8'hFF, 32'hFFFF0000, 1'b1);
    rd(8'hFF, 32'hFF3F7FFF);
    $display("test system done");
    conclude;
  end
endmodule
bind tbw_write_policy tbw_write_policy_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
  .addr_i(addr_i), .select_i(select_i), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
  .wr_done_o(wr_done_o), .wr_refused_o(wr_refused_o), .busy_o(busy_o),
  .erase_armed_o(erase_armed_o), .lock_o(lock_o));
